// *** hw/lbc_cfg.svh ***
// lamp brightness control: offsets, fields, reset values, timing counts
// assumes a 100 MHz core clock and a 32-bit AXI4-Lite register port
`ifndef LBC_CFG_SVH
`define LBC_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define LBC_ADDR_W          8
`define LBC_OFS_CTRL        8'h00
`define LBC_OFS_PROFILE0    8'h04
`define LBC_OFS_PROFILE1    8'h08
`define LBC_OFS_STATUS      8'h0c
`define LBC_OFS_IRQ_STATUS  8'h10
`define LBC_OFS_IRQ_ENABLE  8'h14
`define LBC_OFS_IRQ_CLEAR   8'h18

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define LBC_LEVEL_W         5
`define LBC_LEVEL_MID       5'h10
`define LBC_CTRL_SERIAL     0
`define LBC_CTRL_LAMP_EN    1
`define LBC_CTRL_RESET      2'h2
`define LBC_ST_LAMP_ON      8
`define LBC_ST_CHOP         9
`define LBC_ST_OSC_HIGH     10
`define LBC_ST_SWITCH_ON    11
`define LBC_ST_SHUTDOWN     12
`define LBC_IRQ_W           4
`define LBC_IRQ_OPEN_LAMP   0
`define LBC_IRQ_CUR_LIMIT   1
`define LBC_IRQ_SATURATE    2
`define LBC_IRQ_PRESET      3
`define LBC_RESP_OKAY       2'h0
`define LBC_RESP_SLVERR     2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LBC_CLK_HZ          100000000
`define LBC_OSC_HIGH_HZ     290000
`define LBC_OSC_LOW_HZ      145000
`define LBC_CHOP_HZ         280
`define LBC_OSC_HIGH_CYC    (`LBC_CLK_HZ / `LBC_OSC_HIGH_HZ)
`define LBC_OSC_LOW_CYC     (`LBC_CLK_HZ / `LBC_OSC_LOW_HZ)
`define LBC_CHOP_CYC        (`LBC_CLK_HZ / `LBC_CHOP_HZ)
`define LBC_OSC_CNT_W       10

`endif

// *** hw/lbc_pkg.sv ***
// lamp brightness control: shared types
// assumes nothing beyond a SystemVerilog compiler
package lbc_pkg;

	// ----------------------------------------------------------------
	// pin groups
	// ----------------------------------------------------------------
	typedef struct packed {
		logic osc_sel_high;      // oscillator strap tied to the standard level
		logic floor_level_input; // tied to logic_supply_out: chopping mode
	} lbc_strap_t;

	typedef struct packed {
		logic open_lamp_trip;     // open_lamp_sense above reference
		logic current_limit_trip; // switch_current_sense above loop_comp_node limit
	} lbc_sense_t;

	// ----------------------------------------------------------------
	// power switch states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LBC_SW_WAIT = 2'b01,
		LBC_SW_ON   = 2'b10
	} lbc_sw_state_t;

endpackage

// *** hw/lbc_counter.sv ***
// lamp brightness control: 5-bit up/down brightness counter
// assumes raise and lower are synchronous to clk
`timescale 1ns/10ps
`default_nettype none

module lbc_counter #(
	parameter int W = 5
) (
	input  wire logic         clk,
	input  wire logic         reset_n,
	input  wire logic         raise,
	input  wire logic         lower,
	output logic [W-1:0]      level,
	output logic              preset_evt,
	output logic              limit_evt
);
	localparam logic [W-1:0] MID = {1'b1, {(W-1){1'b0}}};
	localparam logic [W-1:0] TOP = {W{1'b1}};

	logic raise_q;
	logic lower_q;
	logic rise_up;
	logic rise_dn;
	logic both;

	assign rise_up = raise & ~raise_q;
	assign rise_dn = lower & ~lower_q;
	assign both    = raise & lower;

	// ----------------------------------------------------------------
	// edge detection
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			raise_q <= 1'b0;
			lower_q <= 1'b0;
		end else begin
			raise_q <= raise;
			lower_q <= lower;
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level <= MID; // R11
		end else if (both) begin
			level <= MID; // R3
		end else if (rise_up && level != TOP) begin
			level <= level + 1'b1; // R1 R12
		end else if (rise_dn && level != '0) begin
			level <= level - 1'b1; // R2 R12
		end
	end

	// ----------------------------------------------------------------
	// event pulses
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			preset_evt <= 1'b0;
			limit_evt  <= 1'b0;
		end else begin
			preset_evt <= both & ~(raise_q & lower_q);
			limit_evt  <= ~both & ((rise_up & (level == TOP)) | (rise_dn & (level == '0)));
		end
	end

endmodule

`default_nettype wire

// *** hw/lbc_top.sv ***
// lamp brightness control: top level with AXI4-Lite registers
// assumes all pin inputs synchronous to clk, comparators already digital
`timescale 1ns/10ps
`default_nettype none
`include "lbc_cfg.svh"

// Summary of operation
// R1: raise rising edge increments brightness counter
// R2: lower rising edge decrements brightness counter
// R3: both inputs high preset counter mid-scale
// R4: shutdown input low stops lamp drive
// R5: suspend select picks one of two profiles
// R6: strap selects 290kHz or 145kHz oscillator
// R7: floor input strap enables 280Hz chopping
// R8: open lamp trip holds switch off
// R9: current limit trip ends switch on-time
// R10: lamp off discharges the softstart node
// R11: power-up brightness is mid-scale code
// R12: counter saturates at both ends
module lbc_top #(
	parameter int unsigned CHOP_CYC = `LBC_CHOP_CYC
) (
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic [`LBC_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic [2:0]              s_axi_awprot,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [`LBC_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic [2:0]              s_axi_arprot,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    brightness_raise,
	input  wire logic                    brightness_lower,
	input  wire logic                    low_power_off_n,
	input  wire logic                    suspend_profile_select,
	input  wire lbc_pkg::lbc_strap_t     strap,
	input  wire lbc_pkg::lbc_sense_t     sense,
	output logic [`LBC_LEVEL_W-1:0]      dac_level,
	output logic                         power_switch_on,
	output logic                         softstart_discharge,
	output logic                         lamp_on,
	output logic                         irq
);
	localparam int CHOP_W = $clog2(CHOP_CYC + 1);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic is_mapped(input logic [`LBC_ADDR_W-1:0] a);
		return (a == `LBC_OFS_CTRL) || (a == `LBC_OFS_PROFILE0) || (a == `LBC_OFS_PROFILE1) ||
			(a == `LBC_OFS_STATUS) || (a == `LBC_OFS_IRQ_STATUS) || (a == `LBC_OFS_IRQ_ENABLE) ||
			(a == `LBC_OFS_IRQ_CLEAR);
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [1:0]                  ctrl;
	logic [`LBC_LEVEL_W-1:0]     profile0;
	logic [`LBC_LEVEL_W-1:0]     profile1;
	logic [`LBC_IRQ_W-1:0]       irq_status;
	logic [`LBC_IRQ_W-1:0]       irq_enable;
	logic [`LBC_IRQ_W-1:0]       irq_clear;
	logic [`LBC_IRQ_W-1:0]       events;
	logic [`LBC_ADDR_W-1:0]      aw_addr;
	logic                        aw_held;
	logic [31:0]                 w_data;
	logic [3:0]                  w_strb;
	logic                        w_held;
	logic                        do_write;
	logic [`LBC_LEVEL_W-1:0]     counter_level;
	logic [`LBC_LEVEL_W-1:0]     active_level;
	logic                        preset_evt;
	logic                        limit_evt;
	logic [`LBC_OSC_CNT_W-1:0]   osc_cnt;
	logic [`LBC_OSC_CNT_W-1:0]   osc_last;
	logic                        period_start;
	logic [CHOP_W-1:0]           chop_cnt;
	logic [CHOP_W-1:0]           chop_on_cyc;
	logic                        chop_phase_on;
	logic                        lamp_run;
	logic                        open_q;
	lbc_pkg::lbc_sw_state_t      sw_state;
	logic [31:0]                 status_word;

	// ----------------------------------------------------------------
	// write channel
	// ----------------------------------------------------------------
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign do_write      = aw_held & w_held & ~s_axi_bvalid;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held  <= 1'b0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `LBC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= is_mapped(aw_addr) ? `LBC_RESP_OKAY : `LBC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control and profile registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl       <= `LBC_CTRL_RESET;
			profile0   <= `LBC_LEVEL_MID;
			profile1   <= `LBC_LEVEL_MID;
			irq_enable <= '0;
		end else if (do_write) begin
			case (aw_addr)
				`LBC_OFS_CTRL: begin
					ctrl <= 2'(apply_strb({30'h0, ctrl}, w_data, w_strb));
				end
				`LBC_OFS_PROFILE0: begin
					profile0 <= `LBC_LEVEL_W'(apply_strb({27'h0, profile0}, w_data, w_strb));
				end
				`LBC_OFS_PROFILE1: begin
					profile1 <= `LBC_LEVEL_W'(apply_strb({27'h0, profile1}, w_data, w_strb));
				end
				`LBC_OFS_IRQ_ENABLE: begin
					irq_enable <= `LBC_IRQ_W'(apply_strb({28'h0, irq_enable}, w_data, w_strb));
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;

	always_comb begin
		status_word                      = 32'h0;
		status_word[`LBC_LEVEL_W-1:0]    = active_level;
		status_word[`LBC_ST_LAMP_ON]     = lamp_on;
		status_word[`LBC_ST_CHOP]        = strap.floor_level_input;
		status_word[`LBC_ST_OSC_HIGH]    = strap.osc_sel_high;
		status_word[`LBC_ST_SWITCH_ON]   = power_switch_on;
		status_word[`LBC_ST_SHUTDOWN]    = ~low_power_off_n;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `LBC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= is_mapped(s_axi_araddr) ? `LBC_RESP_OKAY : `LBC_RESP_SLVERR;
			case (s_axi_araddr)
				`LBC_OFS_CTRL:       s_axi_rdata <= {30'h0, ctrl};
				`LBC_OFS_PROFILE0:   s_axi_rdata <= {27'h0, profile0};
				`LBC_OFS_PROFILE1:   s_axi_rdata <= {27'h0, profile1};
				`LBC_OFS_STATUS:     s_axi_rdata <= status_word;
				`LBC_OFS_IRQ_STATUS: s_axi_rdata <= {28'h0, irq_status};
				`LBC_OFS_IRQ_ENABLE: s_axi_rdata <= {28'h0, irq_enable};
				default:             s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// brightness source
	// ----------------------------------------------------------------
	lbc_counter #(
		.W (`LBC_LEVEL_W)
	) u_counter (
		.clk        (clk),
		.reset_n    (reset_n),
		.raise      (brightness_raise),
		.lower      (brightness_lower),
		.level      (counter_level),
		.preset_evt (preset_evt),
		.limit_evt  (limit_evt)
	);

	always_comb begin
		if (ctrl[`LBC_CTRL_SERIAL]) begin
			active_level = suspend_profile_select ? profile1 : profile0; // R5
		end else begin
			active_level = counter_level; // R1
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dac_level <= `LBC_LEVEL_MID; // R11
		end else begin
			dac_level <= active_level;
		end
	end

	// ----------------------------------------------------------------
	// switching oscillator
	// ----------------------------------------------------------------
	assign osc_last = strap.osc_sel_high ? `LBC_OSC_CNT_W'(`LBC_OSC_HIGH_CYC - 1)
		: `LBC_OSC_CNT_W'(`LBC_OSC_LOW_CYC - 1); // R6
	assign period_start = (osc_cnt == '0);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_cnt <= '0;
		end else if (osc_cnt >= osc_last) begin
			osc_cnt <= '0; // R6
		end else begin
			osc_cnt <= osc_cnt + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// 280 Hz chopping
	// ----------------------------------------------------------------
	assign chop_on_cyc   = CHOP_W'((64'(CHOP_CYC) * 64'(dac_level)) >> `LBC_LEVEL_W); // R7
	assign chop_phase_on = (chop_cnt < chop_on_cyc);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			chop_cnt <= '0;
		end else if (chop_cnt >= CHOP_W'(CHOP_CYC - 1)) begin
			chop_cnt <= '0; // R7
		end else begin
			chop_cnt <= chop_cnt + 1'b1;
		end
	end

	assign lamp_run = low_power_off_n & ctrl[`LBC_CTRL_LAMP_EN]
		& (~strap.floor_level_input | chop_phase_on); // R4 R7

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lamp_on             <= 1'b0;
			softstart_discharge <= 1'b1;
		end else begin
			lamp_on             <= lamp_run;
			softstart_discharge <= ~lamp_run; // R10
		end
	end

	// ----------------------------------------------------------------
	// power switch
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_state <= lbc_pkg::LBC_SW_WAIT;
		end else if (!lamp_run || sense.open_lamp_trip) begin
			sw_state <= lbc_pkg::LBC_SW_WAIT; // R4 R8
		end else begin
			case (sw_state)
				lbc_pkg::LBC_SW_WAIT: begin
					if (period_start && !sense.current_limit_trip) begin
						sw_state <= lbc_pkg::LBC_SW_ON;
					end
				end
				lbc_pkg::LBC_SW_ON: begin
					if (sense.current_limit_trip) begin
						sw_state <= lbc_pkg::LBC_SW_WAIT; // R9
					end
				end
				default: begin
					sw_state <= lbc_pkg::LBC_SW_WAIT;
				end
			endcase
		end
	end

	assign power_switch_on = (sw_state == lbc_pkg::LBC_SW_ON);

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always_comb begin
		events                     = '0;
		events[`LBC_IRQ_OPEN_LAMP] = sense.open_lamp_trip & ~open_q;
		events[`LBC_IRQ_CUR_LIMIT] = power_switch_on & sense.current_limit_trip;
		events[`LBC_IRQ_SATURATE]  = limit_evt;
		events[`LBC_IRQ_PRESET]    = preset_evt;
	end

	assign irq_clear = (do_write && aw_addr == `LBC_OFS_IRQ_CLEAR && w_strb[0])
		? w_data[`LBC_IRQ_W-1:0] : '0;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			open_q     <= 1'b0;
			irq_status <= '0;
			irq        <= 1'b0;
		end else begin
			open_q     <= sense.open_lamp_trip;
			irq_status <= (irq_status & ~irq_clear) | events;
			irq        <= |(((irq_status & ~irq_clear) | events) & irq_enable);
		end
	end

endmodule

`default_nettype wire

// *** verification/lbc_top_props.sv ***
// lamp brightness control: port checker for lbc_top
// assumes one clk domain with async active-low reset_n; bound below
`timescale 1ns/10ps
`default_nettype none
module lbc_top_props (
	input wire logic		clk,
	input wire logic		reset_n,
	input wire logic [7:0]		s_axi_awaddr,
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic [31:0]		s_axi_wdata,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready,
	input wire logic		s_axi_bvalid,
	input wire logic		s_axi_bready,
	input wire logic		brightness_raise,
	input wire logic		brightness_lower,
	input wire logic		low_power_off_n,
	input wire lbc_pkg::lbc_strap_t	strap,
	input wire lbc_pkg::lbc_sense_t	sense,
	input wire logic [4:0]		dac_level,
	input wire logic		power_switch_on,
	input wire logic		softstart_discharge,
	input wire logic		lamp_on
);
	// ------
	// serial mode tracked from control writes
	// ------
	logic [7:0]	aw_q;
	logic		d0_q;
	logic		serial;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_q <= 8'h00;
			d0_q <= 1'b0;
			serial <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				aw_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				d0_q <= s_axi_wdata[0];
			if (s_axi_bvalid && s_axi_bready && aw_q == 8'h00)
				serial <= d0_q;
		end
	end
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	rst_level_a: assert property (!$past(reset_n) |-> dac_level == 5'h10)
		else $error("level not mid after reset");
	raise_step_a: assert property ($rose(brightness_raise) && !brightness_lower && !serial |-> ##2
		dac_level == ($past(dac_level, 2) == 5'h1f ? 5'h1f : $past(dac_level, 2) + 5'h01))
		else $error("raise step wrong");
	lower_step_a: assert property ($rose(brightness_lower) && !brightness_raise && !serial |-> ##2
		dac_level == ($past(dac_level, 2) == 5'h00 ? 5'h00 : $past(dac_level, 2) - 5'h01))
		else $error("lower step wrong");
	preset_mid_a: assert property (brightness_raise && brightness_lower && !serial |-> ##2 dac_level == 5'h10)
		else $error("preset not mid");
	shutdown_off_a: assert property (!low_power_off_n [*2] |-> !lamp_on && !power_switch_on)
		else $error("drive during shutdown");
	open_lamp_a: assert property (sense.open_lamp_trip [*2] |-> !power_switch_on)
		else $error("switch on with open lamp");
	cur_limit_a: assert property (power_switch_on && sense.current_limit_trip |=> !power_switch_on)
		else $error("on-time not ended");
	softstart_drain_a: assert property (softstart_discharge == !lamp_on)
		else $error("softstart not discharged");
	chop_zero_a: assert property ((strap.floor_level_input && dac_level == 5'h00) [*3] |-> !lamp_on)
		else $error("lamp on at zero chop");
endmodule
bind lbc_top lbc_top_props chk_u (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .brightness_raise(brightness_raise), .brightness_lower(brightness_lower),
	.low_power_off_n(low_power_off_n), .strap(strap), .sense(sense), .dac_level(dac_level),
	.power_switch_on(power_switch_on), .softstart_discharge(softstart_discharge), .lamp_on(lamp_on));
`default_nettype wire

// *** verification/lbc_host_model.sv ***
// lamp brightness control: host pulsing the raise and lower inputs
// assumes its tasks are called just after a rising clk edge
`timescale 1ns/10ps
`default_nettype none
module lbc_host_model (
	input wire logic	clk,
	output var logic	brightness_raise,
	output var logic	brightness_lower
);
	initial begin
		brightness_raise = 1'b0;
		brightness_lower = 1'b0;
	end
	// ------
	// gap sets high and low time in cycles
	// ------
	task automatic step(input logic up, input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			brightness_raise <= up;
			brightness_lower <= !up;
			repeat (gap) @(posedge clk);
			brightness_raise <= 1'b0;
			brightness_lower <= 1'b0;
			repeat (gap - 1) @(posedge clk);
		end
	endtask
	task automatic preset(input int hold);
		@(posedge clk);
		brightness_raise <= 1'b1;
		brightness_lower <= 1'b1;
		repeat (hold) @(posedge clk);
		brightness_raise <= 1'b0;
		brightness_lower <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** verification/lamp_brightness_control_tb_top.sv ***
// lamp brightness control: self-checking bench for lbc_top
// assumes the host model and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module lamp_brightness_control_tb_top;
	localparam int CHOP = 64;
	logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready, off_n, susp;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	lbc_pkg::lbc_strap_t strap;
	lbc_pkg::lbc_sense_t sense;
	wire logic awready, wready, bvalid, arready, rvalid, raise, lower, sw_on, ss_dis, lamp_on, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [4:0] dac_level;
	int failures, check_count;
	lbc_top #(.CHOP_CYC(CHOP)) dut_u (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .brightness_raise(raise), .brightness_lower(lower), .low_power_off_n(off_n),
		.suspend_profile_select(susp), .strap(strap), .sense(sense), .dac_level(dac_level),
		.power_switch_on(sw_on), .softstart_discharge(ss_dis), .lamp_on(lamp_on), .irq(irq));
	lbc_host_model host_u (.clk(clk), .brightness_raise(raise), .brightness_lower(lower));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ------
	// shared tasks
	// ------
	task automatic wrap_up();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic hang();
		failures++;
		$display("unexpected at %0t: wait ran out", $time);
		wrap_up();
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(posedge clk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			hang();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 40 && !done; i++) begin
			@(posedge clk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			hang();
	endtask
	task automatic wait_sw(input logic v);
		int i;
		for (i = 0; i < 2000 && sw_on !== v; i++)
			@(posedge clk);
		if (i == 2000)
			hang();
	endtask
	task automatic pulse_trip();
		sense.current_limit_trip <= 1'b1;
		repeat (2) @(posedge clk);
		sense.current_limit_trip <= 1'b0;
	endtask
	task automatic count(input logic lamp, input int len, output int n);
		n = 0;
		for (int i = 0; i < len; i++) begin
			@(posedge clk);
			n += lamp ? int'(lamp_on === 1'b1) : int'(sw_on === 1'b1);
		end
	endtask
	// ------
	// scenarios
	// ------
	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		chk(32'(dac_level), 32'h10);
		rd(8'h00, d, r);
		chk(d, 32'h2);
		rd(8'h08, d, r);
		chk(d, 32'h10);
		rd(8'h20, d, r);
		chk(32'(r), 32'h2);
		$display("test reset done");
	endtask
	task automatic t_steps();
		logic [31:0] d;
		logic [1:0] r;
		wr(8'h14, 32'h4, r);
		host_u.step(1'b1, 3, 2);
		repeat (3) @(posedge clk);
		chk(32'(dac_level), 32'h13);
		host_u.step(1'b0, 1, 1);
		repeat (3) @(posedge clk);
		chk(32'(dac_level), 32'h12);
		chk(32'(irq), 32'h0);
		host_u.step(1'b1, 16, 1);
		repeat (3) @(posedge clk);
		chk(32'(dac_level), 32'h1f);
		chk(32'(irq), 32'h1);
		rd(8'h10, d, r);
		chk(d, 32'h4);
		wr(8'h18, 32'h4, r);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h0);
		wr(8'h14, 32'h0, r);
		strap.floor_level_input <= 1'b1;
		host_u.step(1'b0, 40, 1);
		repeat (3) @(posedge clk);
		chk(32'(dac_level), 32'h00);
		chk(32'(lamp_on), 32'h0);
		chk(32'(irq), 32'h0);
		strap.floor_level_input <= 1'b0;
		host_u.preset(3);
		repeat (3) @(posedge clk);
		chk(32'(dac_level), 32'h10);
		$display("test steps done");
	endtask
	task automatic t_serial();
		logic [1:0] r;
		wr(8'h04, 32'h05, r);
		wr(8'h08, 32'h1a, r);
		wr(8'h00, 32'h3, r);
		repeat (3) @(posedge clk);
		chk(32'(dac_level), 32'h05);
		susp <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(dac_level), 32'h1a);
		wr(8'h20, 32'h1, r);
		chk(32'(r), 32'h2);
		wr(8'h00, 32'h2, r);
		susp <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(dac_level), 32'h10);
		$display("test serial done");
	endtask
	task automatic t_osc(input logic hi, input int per);
		time t0;
		@(posedge clk);
		strap.osc_sel_high <= hi;
		pulse_trip();
		wait_sw(1'b1);
		t0 = $time;
		pulse_trip();
		chk(32'(sw_on), 32'h0);
		wait_sw(1'b1);
		chk(32'(($time - t0) / 10), 32'(per));
		$display("test oscillator done");
	endtask
	task automatic t_protect();
		int n;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk);
		sense.open_lamp_trip <= 1'b1;
		repeat (2) @(posedge clk);
		count(1'b0, 700, n);
		chk(32'(n), 32'h0);
		sense.open_lamp_trip <= 1'b0;
		wait_sw(1'b1);
		off_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk(32'(lamp_on), 32'h0);
		chk(32'(sw_on), 32'h0);
		chk(32'(ss_dis), 32'h1);
		rd(8'h0c, d, r);
		chk(d, 32'h1010);
		rd(8'h10, d, r);
		chk(d, 32'hf);
		off_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk(32'(ss_dis), 32'h0);
		$display("test protect done");
	endtask
	task automatic t_chop();
		int n;
		@(posedge clk);
		strap.floor_level_input <= 1'b1;
		repeat (CHOP + 4) @(posedge clk);
		count(1'b1, CHOP, n);
		chk(32'(n), 32'((CHOP * 16) >> 5));
		strap.floor_level_input <= 1'b0;
		$display("test chop done");
	endtask
	initial begin
		reset_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, susp} = 6'h00;
		off_n = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		strap = '0;
		sense = '0;
		failures = 0;
		check_count = 0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_steps();
		t_serial();
		t_osc(1'b1, 344);
		t_osc(1'b0, 689);
		t_protect();
		t_chop();
		wrap_up();
	end
endmodule
`default_nettype wire
